// >>> design/psg_pkg.sv
// Purpose: Shared constants for the power status event group
// Assumes: 15-bit status masks, one clock
// Notes:   Command codes select which mask or query is served
package psg_pkg;
  localparam int unsigned PSG_WIDTH = 15;
  localparam logic [14:0] PSG_ENABLE_RST = 15'h7fff;
  localparam logic [14:0] PSG_RISE_RST   = 15'h7fff;
  localparam logic [14:0] PSG_FALL_RST   = 15'h0000;
  localparam logic [14:0] PSG_EVENT_RST  = 15'h0000;
  localparam logic [14:0] PSG_COND_RST   = 15'h0000;
  localparam int unsigned PSG_CAL_HIGH_BIT = 5;
  localparam int unsigned PSG_SUMMARY_BIT  = 3;

  typedef enum logic [2:0] {
    PSG_CMD_WR_ENABLE = 3'h0,
    PSG_CMD_RD_ENABLE = 3'h1,
    PSG_CMD_WR_RISE   = 3'h2,
    PSG_CMD_RD_RISE   = 3'h3,
    PSG_CMD_WR_FALL   = 3'h4,
    PSG_CMD_RD_FALL   = 3'h5,
    PSG_CMD_RD_EVENT  = 3'h6,
    PSG_CMD_RD_COND   = 3'h7
  } psg_cmd_e;
endpackage : psg_pkg

// >>> design/psg_edge_latch.sv
// Purpose: Per-bit transition filter and sticky event latch
// Assumes: cond and prev sampled on the same clock
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ps
module psg_edge_latch #(
  parameter int unsigned WIDTH = 15
) (
  // Inputs
  input  wire logic [WIDTH-1:0] cond,
  input  wire logic [WIDTH-1:0] prev,
  input  wire logic [WIDTH-1:0] rise_edge_filter,
  input  wire logic [WIDTH-1:0] fall_edge_filter,
  input  wire logic [WIDTH-1:0] event_q,
  input  wire logic             clear,
  // Output
  output logic      [WIDTH-1:0] next_event
);
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    logic set_bit;
    assign set_bit = (cond[i] & ~prev[i] & rise_edge_filter[i])
                   | (~cond[i] & prev[i] & fall_edge_filter[i]);
    // Held until a read clears it; fresh edge survives the clear
    assign next_event[i] = set_bit | (event_q[i] & ~clear);
  end
endmodule : psg_edge_latch

// >>> design/psg_power_status.sv
// Purpose: Power status event group: condition, filters, events, summary
// Assumes: One command per cycle from an upstream command parser
// Notes:   Answers come one cycle after the command, in order
`timescale 1ns/1ps
// Functional notes
// - The summary flag is the OR of event bits gated by the enable mask.
// - Masks are 15-bit weighted sums 0..32767; enable presets to 32767.
// - An event query returns the event register's weighted sum; preset 0.
// - Reading the event register clears it in the same access.
// - A condition edge sets an event only through an enabled filter bit.
// - A 1-to-0 edge with its fall filter bit set sets the event; preset 0.
// - A 0-to-1 edge via a set rise filter bit sets the event; preset ones.
// - Condition bit of weight 32 flags calibration input power too high.
// - The condition register mirrors faults live; reading has no effect.
module psg_power_status
  import psg_pkg::*;
#(
  parameter int unsigned WIDTH = psg_pkg::PSG_WIDTH
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // Fault inputs
  input  wire logic [WIDTH-1:0]  fault_in,
  input  wire logic              cal_power_high,
  // Command port
  input  wire logic              cmd_valid,
  input  wire psg_pkg::psg_cmd_e cmd_code,
  input  wire logic [WIDTH-1:0]  cmd_wdata,
  // Answer port
  output logic                   rsp_valid,
  output logic      [WIDTH-1:0]  rsp_data,
  // Summary
  output logic                   power_summary
);
  import psg_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] cond;
    logic [WIDTH-1:0] enable;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
    logic [WIDTH-1:0] events;
    logic             rsp_valid;
    logic [WIDTH-1:0] rsp_data;
    logic             summary;
  } psg_state_s;

  psg_state_s       st;
  psg_state_s       next_st;
  logic [WIDTH-1:0] live_cond;
  logic [WIDTH-1:0] next_event;
  logic             rd_event;

  always_comb begin
    live_cond = fault_in;
    live_cond[PSG_CAL_HIGH_BIT] = cal_power_high;
  end

  assign rd_event = cmd_valid && (cmd_code == PSG_CMD_RD_EVENT);

  psg_edge_latch #(.WIDTH(WIDTH)) u_latch (
    .cond             (live_cond),
    .prev             (st.cond),
    .rise_edge_filter (st.rise),
    .fall_edge_filter (st.fall),
    .event_q          (st.events),
    .clear            (rd_event),
    .next_event       (next_event)
  );

  always_comb begin
    next_st           = st;
    next_st.cond      = live_cond;
    next_st.events    = next_event;
    next_st.rsp_valid = 1'b0;
    // Single-cycle commands, so ordering is inherent
    if (cmd_valid) begin
      next_st.rsp_valid = 1'b1;
      next_st.rsp_data  = '0;
      unique case (cmd_code)
        PSG_CMD_WR_ENABLE: next_st.enable = cmd_wdata;
        PSG_CMD_WR_RISE:   next_st.rise   = cmd_wdata;
        PSG_CMD_WR_FALL:   next_st.fall   = cmd_wdata;
        PSG_CMD_RD_ENABLE: next_st.rsp_data = st.enable;
        PSG_CMD_RD_RISE:   next_st.rsp_data = st.rise;
        PSG_CMD_RD_FALL:   next_st.rsp_data = st.fall;
        PSG_CMD_RD_EVENT:  next_st.rsp_data = st.events;
        PSG_CMD_RD_COND:   next_st.rsp_data = st.cond;
      endcase
    end
    // Summary from next-state events and enable so it matches what a read sees
    next_st.summary = |(next_st.events & next_st.enable);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st.cond      <= PSG_COND_RST;
      st.enable    <= PSG_ENABLE_RST;
      st.rise      <= PSG_RISE_RST;
      st.fall      <= PSG_FALL_RST;
      st.events    <= PSG_EVENT_RST;
      st.rsp_valid <= 1'b0;
      st.rsp_data  <= '0;
      st.summary   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rsp_valid     = st.rsp_valid;
  assign rsp_data      = st.rsp_data;
  assign power_summary = st.summary;

  // Edge math for the checks, kept apart from the latch it checks
  logic [WIDTH-1:0] rise_hits;
  logic [WIDTH-1:0] fall_hits;
  logic [WIDTH-1:0] edge_hits;
  logic [WIDTH-1:0] cal_mask;
  logic             wr_enable;
  logic             wr_rise;
  logic             wr_fall;

  always_comb begin
    cal_mask                   = '0;
    cal_mask[PSG_CAL_HIGH_BIT] = 1'b1;
  end

  assign rise_hits = live_cond & ~st.cond & st.rise;
  assign fall_hits = ~live_cond & st.cond & st.fall;
  assign edge_hits = rise_hits | fall_hits;
  assign wr_enable = cmd_valid && (cmd_code == PSG_CMD_WR_ENABLE);
  assign wr_rise   = cmd_valid && (cmd_code == PSG_CMD_WR_RISE);
  assign wr_fall   = cmd_valid && (cmd_code == PSG_CMD_WR_FALL);

  // Summary flag
  summary_match_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) power_summary == |(st.events & st.enable))
    else $error("summary does not follow gated events");

  summary_rise_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) |(edge_hits & st.enable) && !wr_enable
    |=> power_summary)
    else $error("enabled event did not raise the summary");

  summary_clear_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) rd_event && !(|(edge_hits & st.enable))
    |=> !power_summary)
    else $error("summary stayed up after events were read");

  // Event latch
  event_clear_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) rd_event
    |=> st.events == $past(edge_hits) && rsp_data == $past(st.events))
    else $error("event read did not return and clear");

  event_sticky_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !rd_event |=> (st.events & $past(st.events)) == $past(st.events))
    else $error("event bit lost without a read");

  rise_sets_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    rise_hits != '0 |=> (st.events & $past(rise_hits)) == $past(rise_hits))
    else $error("rising edge through filter not latched");

  fall_sets_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    fall_hits != '0 |=> (st.events & $past(fall_hits)) == $past(fall_hits))
    else $error("falling edge through filter not latched");

  no_filter_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) 1'b1 |=> (st.events & ~$past(st.events)
      & ~($past(st.rise) | $past(st.fall))) == '0)
    else $error("event set without a filter bit");

  // Masks
  enable_write_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) wr_enable |=> st.enable == $past(cmd_wdata))
    else $error("enable write did not land");

  rise_write_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) wr_rise |=> st.rise == $past(cmd_wdata))
    else $error("rise filter write did not land");

  fall_write_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) wr_fall |=> st.fall == $past(cmd_wdata))
    else $error("fall filter write did not land");

  mask_read_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) cmd_valid && cmd_code == PSG_CMD_RD_ENABLE
    |=> rsp_valid && rsp_data == $past(st.enable))
    else $error("enable read mismatch");

  rise_read_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) cmd_valid && cmd_code == PSG_CMD_RD_RISE
    |=> rsp_valid && rsp_data == $past(st.rise))
    else $error("rise filter read mismatch");

  fall_read_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) cmd_valid && cmd_code == PSG_CMD_RD_FALL
    |=> rsp_valid && rsp_data == $past(st.fall))
    else $error("fall filter read mismatch");

  mask_hold_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) !wr_enable |=> $stable(st.enable))
    else $error("enable changed without a write");

  filter_hold_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !wr_rise && !wr_fall |=> $stable(st.rise) && $stable(st.fall))
    else $error("filter changed without a write");

  // Condition register
  cond_live_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    st.cond[PSG_CAL_HIGH_BIT] == $past(cal_power_high))
    else $error("calibration power flag not mirrored");

  cond_mirror_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    1'b1 |=> (st.cond | cal_mask) == ($past(fault_in) | cal_mask))
    else $error("condition register does not mirror faults");

  cond_read_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) cmd_valid && cmd_code == PSG_CMD_RD_COND
    |=> rsp_valid && rsp_data == $past(st.cond))
    else $error("condition read mismatch");

  // Command flow
  answer_once_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) cmd_valid |=> rsp_valid)
    else $error("command not answered next cycle");

  answer_quiet_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) !cmd_valid |=> !rsp_valid)
    else $error("answer given without a command");

  write_answer_a: assert property (@(posedge ref_clk)
    disable iff (!rst_b) wr_enable || wr_rise || wr_fall
    |=> rsp_valid && rsp_data == '0)
    else $error("write answer not zero");
endmodule : psg_power_status

// >>> tb/psg_host_model.sv
// Purpose: Remote controller stand-in issuing status commands
// Assumes: Calls start just after a rising clock edge
// Notes:   Back to back calls keep valid high
`timescale 1ns/1ps
module psg_host_model
  import psg_pkg::*;
(
  // Clock
  input  wire logic          ref_clk,
  // Command port
  output logic               cmd_valid,
  output psg_pkg::psg_cmd_e  cmd_code,
  output logic [14:0]        cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = PSG_CMD_RD_COND;
    cmd_wdata = 15'h0000;
  end
  // One command per edge, answers come back in order
  task automatic issue(psg_cmd_e c, logic [14:0] wd);
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_wdata = wd;
    @(posedge ref_clk);
    #1;
  endtask : issue
  task automatic idle();
    cmd_valid = 1'b0;
    // Stale data must not look like a held value
    cmd_wdata = ~cmd_wdata;
  endtask : idle
endmodule : psg_host_model

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the power status event group
// Assumes: Host model drives commands, bench drives faults
// Notes:   Expected answers wait in a queue in issue order
`timescale 1ns/1ps
module tb_top;
  import psg_pkg::*;
  logic ref_clk, rst_b, cal_power_high, cmd_valid, rsp_valid, power_summary;
  logic [14:0] fault_in, cmd_wdata, rsp_data, m;
  psg_cmd_e    cmd_code;
  logic [14:0] exp_q[$];
  int          err_total, n_tests, i;
  psg_power_status dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .fault_in(fault_in), .cal_power_high(cal_power_high),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .power_summary(power_summary));
  psg_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(string what, logic [14:0] e, logic [14:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic cmd(psg_cmd_e c, logic [14:0] wd, logic [14:0] e);
    exp_q.push_back(e);
    host.issue(c, wd);
  endtask : cmd
  task automatic settle(logic [14:0] f);
    host.idle();
    fault_in = f;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Mid-cycle sampling keeps clear of the edge that launches the answer
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("rsp extra", 15'h0, 15'h1);
      else chk("rsp_data", exp_q.pop_front(), rsp_data);
    end
  end
  initial begin
    rst_b = 1'b0;
    fault_in = 15'h0;
    cal_power_high = 1'b0;
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'h2073f7da));
    repeat (20) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    cmd(PSG_CMD_RD_ENABLE, 15'h0, PSG_ENABLE_RST);
    cmd(PSG_CMD_RD_RISE, 15'h0, PSG_RISE_RST);
    cmd(PSG_CMD_RD_FALL, 15'h0, PSG_FALL_RST);
    cmd(PSG_CMD_RD_EVENT, 15'h0, PSG_EVENT_RST);
    cmd(PSG_CMD_RD_COND, 15'h0, PSG_COND_RST);
    settle(15'h0);
    $display("test presets done");
    for (i = 0; i < 4; i++) begin
      m = 15'($urandom);
      cmd(PSG_CMD_WR_ENABLE, m, 15'h0);
      cmd(PSG_CMD_WR_RISE, ~m, 15'h0);
      cmd(PSG_CMD_WR_FALL, m ^ 15'h5a5a, 15'h0);
      cmd(PSG_CMD_RD_ENABLE, 15'h0, m);
      cmd(PSG_CMD_RD_RISE, 15'h0, ~m);
      cmd(PSG_CMD_RD_FALL, 15'h0, m ^ 15'h5a5a);
    end
    cmd(PSG_CMD_WR_RISE, 15'h0, 15'h0);
    cmd(PSG_CMD_WR_FALL, 15'h0, 15'h0);
    cmd(PSG_CMD_WR_ENABLE, 15'h7fff, 15'h0);
    settle(15'h0);
    $display("test masks done");
    m = (15'($urandom) | 15'h0001) & ~15'h0020;
    settle(m);
    settle(15'h0);
    cmd(PSG_CMD_RD_EVENT, 15'h0, 15'h0);
    cmd(PSG_CMD_WR_RISE, m, 15'h0);
    settle(m);
    chk("power_summary", 15'h1, {14'h0, power_summary});
    settle(15'h0);
    cmd(PSG_CMD_WR_ENABLE, ~m, 15'h0);
    settle(15'h0);
    chk("power_summary", 15'h0, {14'h0, power_summary});
    cmd(PSG_CMD_RD_EVENT, 15'h0, m);
    cmd(PSG_CMD_RD_EVENT, 15'h0, 15'h0);
    cmd(PSG_CMD_WR_RISE, 15'h0, 15'h0);
    cmd(PSG_CMD_WR_FALL, m, 15'h0);
    settle(m);
    settle(15'h0);
    cmd(PSG_CMD_RD_EVENT, 15'h0, m);
    settle(15'h0);
    $display("test events done");
    cal_power_high = 1'b1;
    settle(15'h0);
    cmd(PSG_CMD_RD_COND, 15'h0, 15'h0020);
    cmd(PSG_CMD_RD_COND, 15'h0, 15'h0020);
    settle(m);
    cmd(PSG_CMD_RD_COND, 15'h0, m | 15'h0020);
    settle(15'h0);
    $display("test condition done");
    for (i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge ref_clk);
    if (exp_q.size() > 0) chk("answers pending", 15'h0, 15'(exp_q.size()));
    summarize();
  end
endmodule : tb_top
